// ==== design/wraparound_position_logic.sv ====
// Purpose: position bookkeeping for repetitive and circular motion
// Assumes: step requests come from a ramp generator on sys_clk_i
// Notes:   one step request per cycle at most; zeroing wins over a step
`timescale 1ns/1ps
module wraparound_position_logic
	import wrap_pos_pkg::*;
#(
	parameter int POS_W = 32
)(
	input  wire logic                               sys_clk_i,
	input  wire logic                               rst_n_i,
	input  wire logic                               wr_en_i,
	input  wire logic [wrap_pos_pkg::ADDR_W-1:0]    wr_addr_i,
	input  wire logic [wrap_pos_pkg::DATA_W-1:0]    wr_data_i,
	input  wire logic [wrap_pos_pkg::ADDR_W-1:0]    rd_addr_i,
	output logic      [wrap_pos_pkg::DATA_W-1:0]    rd_data_o,
	input  wire logic [wrap_pos_pkg::RAMP_SEL_W-1:0] ramp_select_i,
	input  wire logic                               zero_at_goal_enable_i,
	input  wire logic                               circular_enable_i,
	input  wire logic [POS_W-1:0]                   goal_position_i,
	input  wire logic                               step_req_i,
	input  wire logic                               step_dir_i,
	output logic      [POS_W-1:0]                   current_position_o,
	output logic      [POS_W-1:0]                   rev_count_o,
	output logic                                    move_dir_o,
	output logic                                    goal_reached_o,
	output logic                                    ramp_done_o,
	output logic                                    ramp_restart_o,
	output logic                                    wrap_hold_o
);
	import wrap_pos_pkg::*;

	frac_accum_if acc_bus ();

	logic [POS_W-1:0]  half_range_q;
	logic [31:0]       frac_ext_q;
	logic [POS_W-1:0]  position_q;
	logic [POS_W-1:0]  position_d;
	logic [POS_W-1:0]  rev_count_q;
	logic [POS_W-1:0]  upper_limit;
	logic [POS_W-1:0]  lower_limit;
	logic              circ_active;
	logic              positioning;
	logic              goal_hit;
	logic              goal_hit_q;
	logic              zeroing;
	logic              wrap_up;
	logic              wrap_down;
	logic              hold_step;
	logic              move_dir_d;
	logic              move_dir_q;
	logic [POS_W:0]    diff;
	logic [POS_W:0]    half_ext;
	wrap_state_t       state_q;
	wrap_state_t       state_d;

	// register writes; half-range is write-only
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			half_range_q <= POS_W'(HALF_RANGE_RST);
		end else if (wr_en_i && wr_addr_i == REG_HALF_RANGE) begin
			half_range_q <= POS_W'(wr_data_i);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			frac_ext_q <= FRAC_EXT_RST;
		end else if (wr_en_i && wr_addr_i == REG_FRAC_EXT) begin
			frac_ext_q <= wr_data_i;
		end
	end

	// reads at the half-range address return the revolution counter
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_data_o <= READ_ZERO;
		end else begin
			case (rd_addr_i)
				REG_HALF_RANGE: rd_data_o <= DATA_W'(rev_count_q);
				REG_FRAC_EXT:   rd_data_o <= frac_ext_q;
				default:        rd_data_o <= READ_ZERO;
			endcase
		end
	end

	// a zero half-range leaves circular motion off even if enabled
	assign circ_active = circular_enable_i && (half_range_q != '0);
	assign positioning = ramp_select_i[RAMP_POS_BIT];
	assign upper_limit = half_range_q - POS_W'(1);
	assign lower_limit = POS_W'(0) - half_range_q;

	assign goal_hit  = positioning && (position_q == goal_position_i);
	assign zeroing   = goal_hit && zero_at_goal_enable_i;

	assign hold_step = circ_active && (state_q != ST_NORMAL);
	assign wrap_up   = circ_active && step_req_i && step_dir_i
		&& !hold_step && (position_q == upper_limit);
	assign wrap_down = circ_active && step_req_i && !step_dir_i
		&& !hold_step && (position_q == lower_limit);

	// next position
	always_comb begin
		position_d = position_q;
		if (zeroing) begin
			position_d = POS_W'(0);
		end else if (step_req_i && !hold_step) begin
			if (wrap_up) begin
				position_d = lower_limit;
			end else if (wrap_down) begin
				position_d = upper_limit;
			end else if (step_dir_i) begin
				position_d = position_q + POS_W'(1);
			end else begin
				position_d = position_q - POS_W'(1);
			end
		end
	end

	// range stays closed while circular motion is active: the only moves past a limit are the wraps above
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			position_q <= POS_W'(POSITION_RST);
		end else begin
			position_q <= position_d;
		end
	end

	// extra held steps after each completed revolution
	assign acc_bus.add   = wrap_up || wrap_down;
	assign acc_bus.clear = !circ_active;
	assign acc_bus.ext   = frac_ext_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_NORMAL: begin
				if (acc_bus.add) begin
					case (acc_bus.carry)
						2'd1:    state_d = ST_HOLD1;
						2'd2:    state_d = ST_HOLD2;
						default: state_d = ST_NORMAL;
					endcase
				end
			end
			ST_HOLD2: begin
				if (step_req_i) begin
					state_d = ST_HOLD1;
				end
			end
			ST_HOLD1: begin
				if (step_req_i) begin
					state_d = ST_NORMAL;
				end
			end
			default: state_d = ST_NORMAL;
		endcase
		if (!circ_active || zeroing) begin
			state_d = ST_NORMAL;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// revolution counter
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rev_count_q <= POS_W'(REV_COUNT_RST);
		end else if (!circ_active) begin
			rev_count_q <= POS_W'(REV_COUNT_RST);
		end else if (!zeroing && wrap_up) begin
			rev_count_q <= rev_count_q + POS_W'(1);
		end else if (!zeroing && wrap_down) begin
			rev_count_q <= rev_count_q - POS_W'(1);
		end
	end

	// shortest path: a gap wider than the half-range is covered via the wrap
	assign diff     = {goal_position_i[POS_W-1], goal_position_i}
		- {position_q[POS_W-1], position_q};
	assign half_ext = {1'b0, half_range_q};

	always_comb begin
		move_dir_d = !diff[POS_W] && (diff != '0);
		if (circ_active && positioning) begin
			if (!diff[POS_W] && ($signed(diff) > $signed(half_ext))) begin
				move_dir_d = 1'b0;
			end else if (diff[POS_W]
				&& ($signed(diff) < -$signed(half_ext))) begin
				move_dir_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			move_dir_q <= 1'b0;
		end else begin
			move_dir_q <= move_dir_d;
		end
	end

	// goal handling pulses fire once per arrival
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			goal_hit_q     <= 1'b0;
			ramp_done_o    <= 1'b0;
			ramp_restart_o <= 1'b0;
		end else begin
			goal_hit_q     <= goal_hit;
			ramp_restart_o <= zeroing && (goal_position_i != '0);
			ramp_done_o    <= goal_hit && !goal_hit_q
				&& !(zeroing && goal_position_i != '0);
		end
	end

	frac_accum u_frac_accum (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.acc       (acc_bus.accum)
	);

	assign current_position_o = position_q;
	assign rev_count_o        = rev_count_q;
	assign move_dir_o         = move_dir_q;
	assign goal_reached_o     = goal_hit_q;
	assign wrap_hold_o        = (state_q != ST_NORMAL);

endmodule : wraparound_position_logic

// ==== common/wrap_pos_pkg.sv ====
// Purpose: shared constants and types for the wraparound position logic
// Assumes: 32-bit positions, 7-bit register addresses
// Notes:   offsets are register addresses on the configuration port
package wrap_pos_pkg;

	localparam int          ADDR_W          = 7;
	localparam int          DATA_W          = 32;
	localparam int          FRAC_BITS       = 31;
	localparam int          RAMP_SEL_W      = 3;
	localparam int          RAMP_POS_BIT    = 2;
	localparam int          HOLD_W          = 2;

	localparam logic [6:0]  REG_HALF_RANGE  = 7'h36;
	localparam logic [6:0]  REG_FRAC_EXT    = 7'h7C;

	localparam logic [31:0] HALF_RANGE_RST  = 32'h0000_0000;
	localparam logic [31:0] FRAC_EXT_RST    = 32'h0000_0000;
	localparam logic [31:0] POSITION_RST    = 32'h0000_0000;
	localparam logic [31:0] REV_COUNT_RST   = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
	localparam logic [30:0] ACCUM_RST       = 31'h0000_0000;

	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_HOLD1  = 2'b01,
		ST_HOLD2  = 2'b10
	} wrap_state_t;

endpackage : wrap_pos_pkg

// ==== common/frac_accum_if.sv ====
// Purpose: carries the revolution-extension accumulator handshake
// Assumes: single clock domain
// Notes:   carry is valid in the cycle add is high
`timescale 1ns/1ps
interface frac_accum_if;
	logic        add;
	logic        clear;
	logic [31:0] ext;
	logic [1:0]  carry;

	modport owner (
		output add,
		output clear,
		output ext,
		input  carry
	);

	modport accum (
		input  add,
		input  clear,
		input  ext,
		output carry
	);
endinterface : frac_accum_if

// ==== design/frac_accum.sv ====
// Purpose: fractional per-revolution accumulator
// Assumes: ext holds one integer bit and 31 fraction bits
// Notes:   carry out of the fraction gives zero, one or two held steps
`timescale 1ns/1ps
module frac_accum
	import wrap_pos_pkg::*;
(
	input  wire logic   sys_clk_i,
	input  wire logic   rst_n_i,
	frac_accum_if.accum acc
);
	import wrap_pos_pkg::*;

	logic [30:0] accum_q;
	logic [32:0] sum;

	// max sum is below 3 * 2^31, so the two carry bits never exceed two
	assign sum       = {2'b00, accum_q} + {1'b0, acc.ext};
	assign acc.carry = sum[32:31];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || acc.clear) begin
			accum_q <= ACCUM_RST;
		end else if (acc.add) begin
			accum_q <= sum[30:0];
		end
	end

endmodule : frac_accum

// ==== tb/ramp_gen_model.sv ====
// Purpose: ramp generator stand-in issuing one step per cycle or slower
// Assumes: run and direction inputs change at the falling clock edge
// Notes:   direction line wanders while no step is offered
`timescale 1ns/1ps
module ramp_gen_model (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic run_i,
	input  wire logic slow_i,
	input  wire logic follow_i,
	input  wire logic dir_i,
	input  wire logic move_dir_i,
	output logic      step_req_o,
	output logic      step_dir_o
);
	logic ph_q;
	always_ff @(posedge sys_clk_i) begin
		ph_q <= rst_n_i ? !ph_q : 1'b0;
	end
	assign step_req_o = run_i && (!slow_i || ph_q);
	// follow mode takes the shortest-path direction from the block
	assign step_dir_o = step_req_o ? (follow_i ? move_dir_i : dir_i) : ph_q;
endmodule : ramp_gen_model

// ==== tb/wrap_pos_chk.sv ====
// Purpose: port-level checks of wrap, hold and goal behaviour
// Assumes: half-range is tracked from writes since it cannot be read
// Notes:   wrap checks only apply while circular motion is active
`timescale 1ns/1ps
module wrap_pos_chk
	import wrap_pos_pkg::*;
#(
	parameter int POS_W = 32
)(
	input wire logic                  sys_clk_i,
	input wire logic                  rst_n_i,
	input wire logic                  wr_en_i,
	input wire logic [ADDR_W-1:0]     wr_addr_i,
	input wire logic [DATA_W-1:0]     wr_data_i,
	input wire logic [RAMP_SEL_W-1:0] ramp_select_i,
	input wire logic                  zero_at_goal_enable_i,
	input wire logic                  circular_enable_i,
	input wire logic [POS_W-1:0]      goal_position_i,
	input wire logic                  step_req_i,
	input wire logic                  step_dir_i,
	input wire logic [POS_W-1:0]      current_position_o,
	input wire logic [POS_W-1:0]      rev_count_o,
	input wire logic                  goal_reached_o,
	input wire logic                  ramp_done_o,
	input wire logic                  ramp_restart_o,
	input wire logic                  wrap_hold_o
);
	logic [POS_W-1:0] rng_q;
	logic             ca, hit, zg, inr;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) rng_q <= '0;
		else if (wr_en_i && wr_addr_i == REG_HALF_RANGE)
			rng_q <= wr_data_i[POS_W-1:0];
	end
	assign ca  = circular_enable_i && rng_q != '0;
	assign hit = ramp_select_i[RAMP_POS_BIT]
		&& current_position_o == goal_position_i;
	assign zg  = hit && zero_at_goal_enable_i;
	assign inr = $signed(current_position_o) >= -$signed(rng_q)
		&& $signed(current_position_o) < $signed(rng_q);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_zero; zg |=> current_position_o == '0; endproperty
	a_zero: assert property (p_zero) else $error("no zeroing at goal");
	property p_restart; zg && goal_position_i != '0 |=> ramp_restart_o; endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_done;
		hit && !zero_at_goal_enable_i && !goal_reached_o
		|=> ramp_done_o && !ramp_restart_o;
	endproperty
	a_done: assert property (p_done) else $error("ramp not ended");
	property p_wrap_up;
		ca && step_req_i && step_dir_i && !wrap_hold_o && !zg
		&& current_position_o == rng_q - 1'b1
		|=> current_position_o == -rng_q
		&& rev_count_o == $past(rev_count_o) + 1'b1;
	endproperty
	a_wrap_up: assert property (p_wrap_up)
		else $error("bad positive wrap");
	property p_wrap_dn;
		ca && step_req_i && !step_dir_i && !wrap_hold_o && !zg
		&& current_position_o == -rng_q
		|=> current_position_o == rng_q - 1'b1
		&& rev_count_o == $past(rev_count_o) - 1'b1;
	endproperty
	a_wrap_dn: assert property (p_wrap_dn)
		else $error("bad negative wrap");
	property p_hold;
		ca && wrap_hold_o && step_req_i && !zg
		|=> $stable(current_position_o);
	endproperty
	a_hold: assert property (p_hold) else $error("held step moved");
	property p_rev0; !circular_enable_i |=> rev_count_o == '0; endproperty
	a_rev0: assert property (p_rev0) else $error("counter not zero");
	property p_range; ca && inr && !wr_en_i |=> inr; endproperty
	a_range: assert property (p_range) else $error("left wrap range");
	c_restart: cover property (ramp_restart_o);
	c_hold: cover property (wrap_hold_o && step_req_i);
	c_done: cover property (ramp_done_o);
endmodule : wrap_pos_chk
bind wraparound_position_logic wrap_pos_chk #(.POS_W(POS_W)) i_chk (.*);

// ==== tb/wraparound_position_logic_tb_top.sv ====
// Purpose: self-checking bench for repetitive and circular positioning
// Assumes: half-range of 4 keeps revolutions short
// Notes:   inputs move on the falling edge, outputs read there too
`timescale 1ns/1ps
module wraparound_position_logic_tb_top;
	import wrap_pos_pkg::*;
	typedef struct packed {logic d; logic [3:0] p; logic r; logic h;} row_t;
	localparam row_t ROWS [11] = '{'{1,1,0,0}, '{1,2,0,0}, '{1,3,0,0},
		'{1,12,1,1}, '{1,12,1,0}, '{1,13,1,0}, '{0,12,1,0}, '{0,3,0,1},
		'{0,3,0,0}, '{0,2,0,0}, '{1,3,0,0}};
	logic sys_clk_i = 0, rst_n_i = 0, wr_en_i = 0, run = 0, slow = 0, follow = 0;
	logic dir = 0, zero_at_goal_enable_i = 0, circular_enable_i = 0;
	logic step_req_i, step_dir_i, move_dir_o, goal_reached_o, ramp_done_o;
	logic ramp_restart_o, wrap_hold_o;
	logic [6:0] wr_addr_i = 0, rd_addr_i = 0;
	logic [2:0] ramp_select_i = 0;
	logic [31:0] wr_data_i = 0, goal_position_i = 0;
	logic [31:0] rd_data_o, current_position_o, rev_count_o;
	int errors = 0, check_count = 0, n;
	always #25 sys_clk_i = ~sys_clk_i;
	wraparound_position_logic i_dut (.*);
	ramp_gen_model i_gen (.sys_clk_i, .rst_n_i, .run_i(run), .slow_i(slow),
		.follow_i(follow), .dir_i(dir), .move_dir_i(move_dir_o),
		.step_req_o(step_req_i), .step_dir_o(step_dir_i));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		wr_en_i = 1; wr_addr_i = a; wr_data_i = d;
		@(negedge sys_clk_i) wr_en_i = 0;
		@(negedge sys_clk_i);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [31:0] e);
		rd_addr_i = a;
		@(negedge sys_clk_i) check(rd_data_o, e);
	endtask : rd
	// run is left high so consecutive calls give back-to-back steps
	task automatic step(input logic d);
		run = 1; dir = d;
		@(negedge sys_clk_i);
	endtask : step
	task wrap_up;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		#(50 * 40000) errors++;
		wrap_up();
	end
	initial begin
		repeat (12) @(negedge sys_clk_i);
		rst_n_i = 1;
		check(current_position_o, 0);
		check(rev_count_o, 0);
		wr(REG_HALF_RANGE, 4);
		wr(REG_FRAC_EXT, 32'h8000_0000);
		circular_enable_i = 1;
		foreach (ROWS[i]) begin
			step(ROWS[i].d);
			check(current_position_o, {{28{ROWS[i].p[3]}}, ROWS[i].p});
			check(rev_count_o, 32'(ROWS[i].r));
			check(32'(ROWS[i].h), 32'(wrap_hold_o));
		end
		run = 0;
		wr(REG_FRAC_EXT, 32'hA000_0000);
		// fourth revolution carries twice out of the fraction
		for (int r = 0; r < 4; r++) begin
			step(1);
			n = 0;
			while (wrap_hold_o === 1'b1 && n < 4) begin
				step(1);
				n++;
				check(current_position_o, 32'hFFFF_FFFC);
			end
			check(n, r == 3 ? 2 : 1);
			repeat (7) step(1);
			check(current_position_o, 3);
		end
		run = 0;
		check(rev_count_o, 4);
		rd(REG_HALF_RANGE, 4);
		rd(REG_FRAC_EXT, 32'hA000_0000);
		wr(7'h10, 5);
		rd(7'h10, 0);
		rd(REG_FRAC_EXT, 32'hA000_0000);
		circular_enable_i = 0;
		// the counter clears on the first edge; its read lands one later
		@(negedge sys_clk_i);
		rd(REG_HALF_RANGE, 0);
		wr(REG_FRAC_EXT, 0);
		circular_enable_i = 1;
		ramp_select_i = 3'h4;
		goal_position_i = 32'hFFFF_FFFD;
		repeat (2) @(negedge sys_clk_i);
		check(move_dir_o, 1);
		goal_position_i = 1;
		repeat (2) @(negedge sys_clk_i);
		check(move_dir_o, 0);
		goal_position_i = 32'hFFFF_FFFD;
		follow = 1;
		@(negedge sys_clk_i) run = 1;
		repeat (2) @(negedge sys_clk_i);
		run = 0;
		check(current_position_o, 32'hFFFF_FFFD);
		@(negedge sys_clk_i) check(ramp_done_o, 1);
		check(goal_reached_o, 1);
		check(current_position_o, 32'hFFFF_FFFD);
		circular_enable_i = 0;
		zero_at_goal_enable_i = 1;
		goal_position_i = 2;
		slow = 1;
		run = 1;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge sys_clk_i);
				n++;
			end while (ramp_restart_o !== 1'b1 && n < 40);
			check(ramp_restart_o, 1);
			check(current_position_o, 0);
			goal_position_i = 1;
		end
		run = 0;
		wrap_up();
	end
endmodule : wraparound_position_logic_tb_top
